// ---- pkg/ccbe_cfg.svh ----
// Constants for the call, clear and branch execution slice.
// Assumes inclusion by bare name from the package and the core.
`ifndef CCBE_CFG_SVH
`define CCBE_CFG_SVH
`define CCBE_OP_BRANCH_ZERO 8'he0
`define CCBE_OP_CALL_HI   7'h76
`define CCBE_OP_CALL_LO2  4'hf
`define CCBE_OP_CLEAR_FILE 7'h35
`define CCBE_OP_COMPLEMENT 6'h07
`define CCBE_OP_CLEAR_WDT 16'h0004
`define CCBE_PC_W         21
`define CCBE_ST_Z         2
`define CCBE_ST_N         4
`define CCBE_ACCESS_BANK  4'h0
`define CCBE_ACCESS_SPLIT 8'h80
`define CCBE_ACCESS_HIGH  4'hf
`endif

// ---- pkg/ccbe_pkg.sv ----
// Types for the call, clear and branch execution slice.
// Assumes the constants header is on the include path.
`include "ccbe_cfg.svh"
package ccbe_pkg;
  typedef enum logic [1:0] {CCBE_Q1, CCBE_Q2, CCBE_Q3, CCBE_Q4} ccbe_phase_e;
  typedef enum logic [1:0] {CCBE_RUN, CCBE_CALL2, CCBE_NOP} ccbe_state_e;
  typedef struct packed {
    logic       we;
    logic [11:0] addr;
    logic [7:0] data;
  } ccbe_fwr_s;
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [3:0] bank_sel;
  } ccbe_shadow_s;
endpackage

// ---- core/ccbe_core.sv ----
// Execution core for branch-on-zero, call, clear, clear-watchdog and complement.
// Assumes one instruction word per cycle on i_instr, valid in phase one,
// and a file register read value on i_file_rdata by phase three.
`timescale 1ns/1ps
`include "ccbe_cfg.svh"

// Notes on behaviour
// - Branch-on-zero adds twice the signed offset to PC+2 when zero set.
// - Branch-on-zero: one cycle if not taken, taken adds one no-op cycle.
// - Call pushes PC+4 onto the return stack top first.
// - Fast call copies work, status and bank select into shadows.
// - Call then loads the 20-bit target into PC bits 20:1.
// - Call takes two cycles; push in phase three, PC write phase four.
// - Call is two words: 1110110s k7:0 then 1111 k19:8.
// - Clear-register writes zero to the file register and sets zero flag.
// - Clear-register decodes as 0110101a with an 8-bit address.
// - Access bit 0 picks the access bank, 1 uses bank select.
module ccbe_core
  import ccbe_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic [15:0]        i_instr,
  input  wire logic [7:0]         i_file_rdata,
  input  wire logic [3:0]         i_bank_select_reg,
  output logic [`CCBE_PC_W-1:0]   o_pc,
  output logic [`CCBE_PC_W-1:0]   o_return_stack_top,
  output logic                    o_push,
  output ccbe_fwr_s               o_fwr,
  output logic [7:0]              o_work,
  output logic [7:0]              o_status,
  output ccbe_shadow_s            o_shadow,
  output logic [7:0]              o_wdt_count,
  output logic [7:0]              o_wdt_post,
  output logic                    o_timeout_flag,
  output logic                    o_power_down_flag
);

  // ==========================================================================
  // Phase sequencing and decode
  ccbe_phase_e phase_r;
  ccbe_state_e state_r;
  logic [7:0]  call_lo_r;
  logic        call_fast_r;
  logic [15:0] ir_r;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_r <= CCBE_Q1;
    end else begin
      phase_r <= ccbe_phase_e'(phase_r + 2'd1);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ir_r <= 16'h0000;
    end else if (phase_r == CCBE_Q1) begin
      ir_r <= i_instr;
    end
  end

  logic dec_branch, dec_call, dec_clear, dec_compl, dec_wdt, active;
  assign active     = (state_r == CCBE_RUN);
  assign dec_branch = active && ir_r[15:8] == `CCBE_OP_BRANCH_ZERO;
  assign dec_call   = active && ir_r[15:9] == `CCBE_OP_CALL_HI;
  assign dec_clear  = active && ir_r[15:9] == `CCBE_OP_CLEAR_FILE;
  assign dec_compl  = active && ir_r[15:10] == `CCBE_OP_COMPLEMENT;
  assign dec_wdt    = active && ir_r == `CCBE_OP_CLEAR_WDT;

  logic z_now;
  assign z_now = o_status[`CCBE_ST_Z];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= CCBE_RUN;
    end else if (phase_r == CCBE_Q4) begin
      unique case (state_r)
        CCBE_RUN: begin
          if (dec_call) begin
            state_r <= CCBE_NOP;
          end else if (dec_branch && z_now) begin
            state_r <= CCBE_NOP;
          end
        end
        CCBE_CALL2: state_r <= CCBE_NOP;
        CCBE_NOP:   state_r <= CCBE_RUN;
      endcase
    end
  end

  // First call word's s bit and k7:0 are latched here in phase two; the second word is read from i_instr in phase four.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      call_lo_r   <= 8'h00;
      call_fast_r <= 1'b0;
    end else if (phase_r == CCBE_Q2 && dec_call) begin
      call_lo_r   <= ir_r[7:0];
      call_fast_r <= ir_r[8];
    end
  end

  // ==========================================================================
  // Program counter and return stack
  logic [`CCBE_PC_W-1:0] pc_inc, branch_target;
  assign pc_inc        = o_pc + `CCBE_PC_W'(2);
  assign branch_target = pc_inc + `CCBE_PC_W'({{13{ir_r[7]}}, ir_r[7:0]} <<< 1);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pc <= `CCBE_PC_W'(0);
    end else if (phase_r == CCBE_Q4) begin
      if (dec_call) begin
        o_pc <= {i_instr[11:0], call_lo_r, 1'b0};
      end else if (dec_branch && z_now) begin
        o_pc <= branch_target;
      end else if (state_r != CCBE_NOP) begin
        o_pc <= pc_inc;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_return_stack_top <= `CCBE_PC_W'(0);
      o_push             <= 1'b0;
    end else begin
      o_push <= (phase_r == CCBE_Q3) && dec_call;
      if (phase_r == CCBE_Q3 && dec_call) begin
        o_return_stack_top <= o_pc + `CCBE_PC_W'(4);
      end
    end
  end

  // ==========================================================================
  // Shadow copies
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_shadow <= '0;
    end else if (phase_r == CCBE_Q3 && dec_call && call_fast_r) begin
      o_shadow <= '{w: o_work, status: o_status, bank_sel: i_bank_select_reg};
    end
  end

  // ==========================================================================
  // File register datapath
  logic [11:0] faddr;
  logic [7:0]  comp;
  always_comb begin
    if (ir_r[8]) begin
      faddr = {i_bank_select_reg, ir_r[7:0]};
    end else if (ir_r[7:0] < `CCBE_ACCESS_SPLIT) begin
      faddr = {`CCBE_ACCESS_BANK, ir_r[7:0]};
    end else begin
      faddr = {`CCBE_ACCESS_HIGH, ir_r[7:0]};
    end
  end
  assign comp = ~i_file_rdata;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fwr <= '0;
    end else begin
      o_fwr.we <= 1'b0;
      if (phase_r == CCBE_Q4 && dec_clear) begin
        o_fwr <= '{we: 1'b1, addr: faddr, data: 8'h00};
      end else if (phase_r == CCBE_Q4 && dec_compl && ir_r[9]) begin
        o_fwr <= '{we: 1'b1, addr: faddr, data: comp};
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_work <= 8'h00;
    end else if (phase_r == CCBE_Q4 && dec_compl && !ir_r[9]) begin
      o_work <= comp;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status <= 8'h00;
    end else if (phase_r == CCBE_Q4) begin
      if (dec_clear) begin
        o_status[`CCBE_ST_Z] <= 1'b1;
      end else if (dec_compl) begin
        o_status[`CCBE_ST_Z] <= (comp == 8'h00);
        o_status[`CCBE_ST_N] <= comp[7];
      end
    end
  end

  // ==========================================================================
  // Watchdog clear; the counter itself runs elsewhere, this holds its cleared image.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wdt_count       <= 8'h00;
      o_wdt_post        <= 8'h00;
      o_timeout_flag    <= 1'b1;
      o_power_down_flag <= 1'b1;
    end else if (phase_r == CCBE_Q3 && dec_wdt) begin
      o_wdt_count       <= 8'h00;
      o_wdt_post        <= 8'h00;
      o_timeout_flag    <= 1'b1;
      o_power_down_flag <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_call_q3;
    phase_r == CCBE_Q3 && dec_call;
  endsequence

  a_call_push: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_call_q3 |=> o_push && o_return_stack_top == $past(o_pc) + `CCBE_PC_W'(4))
    else $error("call push address wrong");
  a_call_two_cycles: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_call_q3 ##1 1 |=> state_r == CCBE_NOP [*4] ##1 state_r == CCBE_RUN)
    else $error("call not two cycles");
  a_call_target: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (phase_r == CCBE_Q4 && dec_call) |=> o_pc[0] == 1'b0 && o_pc[8:1] == $past(ir_r[7:0])
      && o_pc[20:9] == $past(i_instr[11:0]))
    else $error("call target wrong");
  a_shadow_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (s_call_q3 and !ir_r[8]) |=> $stable(o_shadow))
    else $error("shadow changed on slow call");
  a_branch_taken: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (phase_r == CCBE_Q4 && dec_branch && z_now)
      |=> o_pc == $past(branch_target) ##1 state_r == CCBE_NOP)
    else $error("branch target wrong");
  a_branch_skip: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (phase_r == CCBE_Q4 && dec_branch && !z_now)
      |=> state_r == CCBE_RUN && o_pc == $past(pc_inc))
    else $error("untaken branch misbehaved");
  a_clear_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (phase_r == CCBE_Q4 && dec_clear)
      |=> o_fwr.we && o_fwr.data == 8'h00 && o_status[`CCBE_ST_Z])
    else $error("clear register wrong");
  a_bank_access: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (phase_r == CCBE_Q4 && dec_clear && !ir_r[8] && !ir_r[7]) |=> o_fwr.addr[11:8] == 4'h0)
    else $error("access bank not used");
  a_wdt_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (phase_r == CCBE_Q3 && dec_wdt)
      |=> o_wdt_count == 8'h00 && o_wdt_post == 8'h00 && o_timeout_flag && o_power_down_flag)
    else $error("watchdog clear wrong");
  a_complement_file_reg_work: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (phase_r == CCBE_Q4 && dec_compl && !ir_r[9]) |=> o_work == ~$past(i_file_rdata))
    else $error("complement to work wrong");

endmodule

// ---- tb/call_clear_branch_exec_tb.sv ----
// Self-checking bench for the branch, call, clear, watchdog and complement core.
// Assumes the core keeps phase from reset release and takes one word every 4 clocks.
`timescale 1ns/1ps
module call_clear_branch_exec_tb
  import ccbe_pkg::*;
();
  // ==========================================
  // Stimulus and observed signals
  localparam logic [15:0] JUNK = 16'h6a33;
  localparam logic [15:0] FILL = 16'h0000;
  logic         i_ref_clk         = 1'b0;
  logic         i_rst             = 1'b1;
  logic [15:0]  i_instr           = 16'h0000;
  logic [7:0]   i_file_rdata      = 8'h00;
  logic [3:0]   i_bank_select_reg = 4'h0;
  logic [20:0]  o_pc;
  logic [20:0]  o_return_stack_top;
  logic         o_push;
  ccbe_fwr_s    o_fwr;
  logic [7:0]   o_work;
  logic [7:0]   o_status;
  ccbe_shadow_s o_shadow;
  logic [7:0]   o_wdt_count;
  logic [7:0]   o_wdt_post;
  logic         o_timeout_flag;
  logic         o_power_down_flag;
  logic [20:0]  s_pc;
  logic [20:0]  s_stack_top;
  ccbe_shadow_s s_sh;
  ccbe_fwr_s    s_fwr;
  ccbe_fwr_s    fwr_acc;
  logic         s_we;
  logic         s_push;
  logic         we_acc      = 1'b0;
  logic         push_acc    = 1'b0;
  int           miscompares = 0;
  int           n_compared  = 0;
  int           cycles      = 0;

  always #2.5 i_ref_clk = ~i_ref_clk;

  ccbe_core u_ccbe_core (
    .i_ref_clk         (i_ref_clk),
    .i_rst             (i_rst),
    .i_instr           (i_instr),
    .i_file_rdata      (i_file_rdata),
    .i_bank_select_reg (i_bank_select_reg),
    .o_pc              (o_pc),
    .o_return_stack_top(o_return_stack_top),
    .o_push            (o_push),
    .o_fwr             (o_fwr),
    .o_work            (o_work),
    .o_status          (o_status),
    .o_shadow          (o_shadow),
    .o_wdt_count       (o_wdt_count),
    .o_wdt_post        (o_wdt_post),
    .o_timeout_flag    (o_timeout_flag),
    .o_power_down_flag (o_power_down_flag)
  );

  // ==========================================
  // Reporting
  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_pc(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_v(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles >= 400) begin
      miscompares++;
      wrap_up();
    end
  end

  // ==========================================
  // Instruction driver
  // Pulses of one instruction can land in the first cycle of the next, so
  // results are snapshotted at the first falling edge of the following issue.
  task automatic issue(input logic [15:0] ins, input logic [7:0] rd, input logic [3:0] bank,
                       input logic [15:0] w2, input int cyc);
    for (int i = 0; i < cyc; i++) begin
      @(posedge i_ref_clk);
      if (i == 0) begin
        i_instr           <= ins;
        i_file_rdata      <= rd;
        i_bank_select_reg <= bank;
      end
      if (i == 3 && cyc == 8) i_instr <= w2;
      if (i == 4) i_instr <= JUNK;
      @(negedge i_ref_clk);
      if (o_fwr.we === 1'b1) begin
        we_acc  = 1'b1;
        fwr_acc = o_fwr;
      end
      if (o_push === 1'b1) push_acc = 1'b1;
      if (i == 0) begin
        s_pc     = o_pc;
        s_stack_top = o_return_stack_top;
        s_sh     = o_shadow;
        s_we     = we_acc;
        s_fwr    = fwr_acc;
        s_push   = push_acc;
        we_acc   = 1'b0;
        push_acc = 1'b0;
      end
    end
  endtask

  task automatic expect_res(input logic [20:0] pc, input logic we, input logic [11:0] addr,
                            input logic [7:0] st, input logic [7:0] wk, input logic push);
    chk_pc(s_pc, pc);
    chk_v({11'h000, s_we}, {11'h000, we});
    if (we) chk_v(s_fwr.addr, addr);
    if (we) chk_v({4'h0, s_fwr.data}, 12'h000);
    chk_v({4'h0, o_status}, {4'h0, st});
    chk_v({4'h0, o_work}, {4'h0, wk});
    chk_v({11'h000, s_push}, {11'h000, push});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_clear();
    issue(16'he005, 8'h5a, 4'h5, JUNK, 4);
    issue(16'h6a10, 8'h5a, 4'h5, JUNK, 4);
    expect_res(21'h004, 1'b0, 12'h000, 8'h00, 8'h00, 1'b0);
    issue(16'h6a90, 8'h5a, 4'h5, JUNK, 4);
    expect_res(21'h006, 1'b1, 12'h010, 8'h04, 8'h00, 1'b0);
    issue(16'h6b22, 8'h5a, 4'h5, JUNK, 4);
    expect_res(21'h008, 1'b1, 12'hf90, 8'h04, 8'h00, 1'b0);
    issue(FILL, 8'h5a, 4'h5, JUNK, 4);
    expect_res(21'h00a, 1'b1, 12'h522, 8'h04, 8'h00, 1'b0);
  endtask

  task automatic t_taken();
    issue(16'he0fd, 8'h00, 4'h5, JUNK, 8);
    issue(FILL, 8'h00, 4'h5, JUNK, 4);
    expect_res(21'h008, 1'b0, 12'h000, 8'h04, 8'h00, 1'b0);
  endtask

  task automatic t_comp();
    issue(16'h1c10, 8'h13, 4'h5, JUNK, 4);
    issue(16'h1f11, 8'hff, 4'h5, JUNK, 4);
    expect_res(21'h00c, 1'b0, 12'h000, 8'h10, 8'hec, 1'b0);
    issue(FILL, 8'h00, 4'h5, JUNK, 4);
    expect_res(21'h00e, 1'b1, 12'h511, 8'h04, 8'hec, 1'b0);
  endtask

  task automatic t_call();
    issue(16'hed45, 8'h00, 4'h5, 16'hf123, 8);
    issue(16'hecbc, 8'h00, 4'h9, 16'hf00a, 8);
    expect_res(21'h2468a, 1'b0, 12'h000, 8'h04, 8'hec, 1'b1);
    chk_pc(s_stack_top, 21'h014);
    chk_pc({1'b0, s_sh}, {1'b0, 8'hec, 8'h04, 4'h5});
    issue(FILL, 8'h00, 4'h9, JUNK, 4);
    expect_res(21'h01578, 1'b0, 12'h000, 8'h04, 8'hec, 1'b1);
    chk_pc(s_stack_top, 21'h2468e);
    chk_pc({1'b0, s_sh}, {1'b0, 8'hec, 8'h04, 4'h5});
  endtask

  task automatic t_wdt();
    issue(16'h0004, 8'h00, 4'h9, JUNK, 4);
    issue(FILL, 8'h00, 4'h9, JUNK, 4);
    expect_res(21'h0157c, 1'b0, 12'h000, 8'h04, 8'hec, 1'b0);
    chk_pc({5'h00, o_wdt_post, o_wdt_count}, 21'h00000);
    chk_v({10'h000, o_timeout_flag, o_power_down_flag}, 12'h003);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk_pc(o_pc, 21'h0);
    chk_v({10'h000, o_timeout_flag, o_power_down_flag}, 12'h003);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    t_clear();
    t_taken();
    t_comp();
    t_call();
    t_wdt();
    wrap_up();
  end
endmodule
